/* File: hdl/swac_pkg.sv */
// Package: constants and helpers for the reference window and calibration block
package swac_pkg;
   localparam int STAT_W = 24;
   localparam int SEL_W = 4;
   localparam int TAD_W = 8;
   localparam int AXI_AW = 10;
   localparam int IRQ_N = 3;
   // ----------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------
   localparam logic [7:0] IDX_CLK_CTRL = 8'h29;
   localparam logic [7:0] IDX_STAT_LO = 8'h2C;
   localparam logic [7:0] IDX_STAT_MID = 8'h2D;
   localparam logic [7:0] IDX_STAT_HI = 8'h2E;
   localparam logic [7:0] IDX_CAL_EN = 8'h2F;
   localparam logic [7:0] IDX_CAL_CFG = 8'h30;
   localparam logic [7:0] IDX_CAL_STAT = 8'h31;
   localparam logic [7:0] IDX_TAD = 8'h32;
   localparam logic [7:0] IDX_INT_STAT = 8'h33;
   localparam logic [7:0] IDX_INT_EN = 8'h34;
   localparam logic [7:0] IDX_INT_CLR = 8'h35;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_ZOOM_BIT = 4;
   localparam int COARSE_DELAY_LSB = 8;
   localparam int CLOCK_INVERT_BIT = 16;
   localparam int IRQ_CAL_DONE = 0;
   localparam int IRQ_WIN_CHG = 1;
   localparam int IRQ_CAPT = 2;
   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
   localparam logic ZOOM_RST = 1'b1;
   localparam logic [7:0] CAL_CFG_RST = 8'h20;
   localparam logic [TAD_W-1:0] TAD_RST = 8'h00;
   localparam logic [TAD_W-1:0] COARSE_LAST = 8'hFF;
   localparam logic [STAT_W-1:0] STAT_RST = 24'h800001;
   localparam logic [11:0] WIN_DET_CYC = 12'hFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      CAL_IDLE = 4'h1,
      CAL_WAIT = 4'h2,
      CAL_CHK = 4'h4,
      CAL_DONE = 4'h8
   } swac_cal_st_t;

   function automatic logic [7:0] word_idx(input logic [AXI_AW-1:0] a);
      return a[AXI_AW-1:2];
   endfunction

   function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction
endpackage

/* File: hdl/swac_win.sv */
// Window detector: marks delay taps that sit in a reference transition region
`timescale 1ns/1ps
`default_nettype none
module swac_win
   import swac_pkg::*;
#(
   parameter int W = STAT_W,
   parameter logic [11:0] DET = WIN_DET_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic restart_in,
   input wire logic [W-1:0] taps_in,
   output logic [W-1:0] status_out,
   output logic chg_out
);
   localparam logic [W-1:0] EDGE = {1'b1, {(W-2){1'b0}}, 1'b1};

   typedef struct packed {
      logic [11:0] cnt;
      logic [W-1:0] acc;
      logic [W-1:0] status;
      logic chg;
   } swac_win_t;
   swac_win_t q, d;
   logic [W-1:0] viol;

   // A tap that disagrees with a neighbour lies in the transition region
   assign viol = (taps_in ^ (taps_in << 1)) | (taps_in ^ (taps_in >> 1));

   always_comb begin
      d = q;
      d.chg = 1'b0;
      d.acc = q.acc | viol;
      if (restart_in) begin
         d.acc = '0;
         d.cnt = DET;
      end else if (q.cnt == 12'h000) begin
         d.status = q.acc | viol | EDGE;
         d.chg = (d.status != q.status);
         d.acc = '0;
         d.cnt = DET;
      end else begin
         d.cnt = q.cnt - 12'h001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
         q.cnt <= DET;
         q.status <= EDGE;
      end else if (ce_in) begin
         q <= d;
      end
   end

   assign status_out = q.status;
   assign chg_out = q.chg;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_edge_bits: assert property (status_out[0] && status_out[W-1])
      else $error("outer window bits not set");
   chk_win_period: assert property ($changed(status_out) |-> $past(q.cnt) == 12'h000)
      else $error("window status changed outside interval end");
endmodule
`default_nettype wire

/* File: hdl/swac_cal.sv */
// Calibration engine: sweeps coarse delay at invert 0, then at invert 1, keeping the smallest setting where clock and reference align
`timescale 1ns/1ps
`default_nettype none
module swac_cal
   import swac_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic en_in,
   input wire logic [7:0] settle_in,
   input wire logic align_in,
   output logic inv_out,
   output logic [TAD_W-1:0] coarse_out,
   output logic busy_out,
   output logic done_out,
   output logic found_out,
   output logic res_inv_out,
   output logic [TAD_W-1:0] res_coarse_out
);
   typedef struct packed {
      swac_cal_st_t st;
      logic inv;
      logic [TAD_W-1:0] coarse;
      logic [7:0] cnt;
      logic found;
      logic rinv;
      logic [TAD_W-1:0] rcoarse;
   } swac_calq_t;
   swac_calq_t q, d;

   always_comb begin
      logic last;
      last = 1'b0;
      d = q;
      case (q.st)
         CAL_IDLE: begin
            if (en_in) begin
               d.st = CAL_WAIT;
               d.inv = 1'b0;
               d.coarse = TAD_RST;
               d.cnt = settle_in;
               d.found = 1'b0;
               d.rinv = 1'b0;
               d.rcoarse = TAD_RST;
            end
         end
         CAL_WAIT: begin
            if (q.cnt == 8'h00) begin
               d.st = CAL_CHK;
            end else begin
               d.cnt = q.cnt - 8'h01;
            end
         end
         CAL_CHK: begin
            // Second pass stops once it cannot beat the first result
            last = align_in || (q.coarse == COARSE_LAST) || (q.inv && q.found && q.coarse >= q.rcoarse);
            if (align_in && (!q.found || q.coarse < q.rcoarse)) begin
               d.found = 1'b1;
               d.rinv = q.inv;
               d.rcoarse = q.coarse;
            end
            if (!last) begin
               d.coarse = q.coarse + 8'h01;
               d.cnt = settle_in;
               d.st = CAL_WAIT;
            end else if (!q.inv) begin
               d.inv = 1'b1;
               d.coarse = TAD_RST;
               d.cnt = settle_in;
               d.st = CAL_WAIT;
            end else begin
               d.st = CAL_DONE;
            end
         end
         CAL_DONE: begin
         end
         default: begin
            d.st = CAL_IDLE;
         end
      endcase
      if (!en_in) begin
         d.st = CAL_IDLE;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
         q.st <= CAL_IDLE;
      end else if (ce_in) begin
         q <= d;
      end
   end

   assign inv_out = q.inv;
   assign coarse_out = q.coarse;
   assign busy_out = (q.st == CAL_WAIT) || (q.st == CAL_CHK);
   assign done_out = (q.st == CAL_DONE);
   assign found_out = q.found;
   assign res_inv_out = q.rinv;
   assign res_coarse_out = q.rcoarse;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_coarse_step: assert property (ce_in && en_in && q.st == CAL_CHK && !align_in
      && q.coarse != COARSE_LAST && !(q.inv && q.found) |=> q.coarse == $past(q.coarse) + 8'h01)
      else $error("coarse sweep did not advance by one");
   chk_both_pol: assert property ($rose(q.st == CAL_DONE) |-> $past(q.inv))
      else $error("calibration ended before inverted pass");
   chk_done_hold: assert property (q.st == CAL_DONE && $past(q.st == CAL_DONE)
      |-> $stable(q.rcoarse) && $stable(q.rinv))
      else $error("calibration result moved after done");
endmodule
`default_nettype wire

/* File: hdl/swac_top.sv */
// Top: reference window, calibration control and register slave
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Summary of operation
// - Record reference position against 24 delayed sampling taps in window status.
// - A status bit is 1 for a risky tap, 0 for a valid one.
// - Status bits 0 and 23 always read as 1.
// - Window select holds a tap index, only taps 0 to 15 selectable.
// - Window zoom 0 gives coarse tap steps, 1 gives fine steps.
// - The reference is captured on the delay tap chosen by window select.
// - Enabled calibration searches delay until clock falling edge meets reference edge.
// - Search sweeps coarse delay at both invert settings, keeping the smallest.
// - The found delay setting is shown in the calibration result field.
// - Calibrated delay stays in use; software may later override it.
// - Clock invert adds half a period, independent of other delays.
// ----------------------------------------
module swac_top
   import swac_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic ARST_N_IN,
   input wire logic CE_IN,
   input wire logic [AXI_AW-1:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [AXI_AW-1:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic [STAT_W-1:0] SYSREF_TAPS_IN,
   input wire logic ALIGN_IN,
   output logic WINDOW_ZOOM_OUT,
   output logic SYSREF_CAPT_OUT,
   output logic CLOCK_INVERT_OUT,
   output logic [TAD_W-1:0] COARSE_DELAY_OUT,
   output logic [TAD_W-1:0] FINE_DELAY_OUT,
   output logic CAL_DONE_OUT,
   output logic IRQ_OUT
);
   typedef struct packed {
      logic [STAT_W-1:0] tap_s1;
      logic [STAT_W-1:0] tap_s2;
      logic al_s1;
      logic al_s2;
      logic [SEL_W-1:0] sel;
      logic zoom;
      logic cal_en;
      logic [7:0] cfg;
      logic tinv;
      logic [TAD_W-1:0] tcoarse;
      logic [TAD_W-1:0] tfine;
      logic [IRQ_N-1:0] ist;
      logic [IRQ_N-1:0] ien;
      logic irq;
      logic awrdy;
      logic wrdy;
      logic bvld;
      logic [1:0] bresp;
      logic arrdy;
      logic rvld;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic capt;
      logic o_inv;
      logic [TAD_W-1:0] o_coarse;
      logic [TAD_W-1:0] o_fine;
      logic done_q;
   } swac_top_t;
   swac_top_t q, d;

   logic [STAT_W-1:0] win_status;
   logic win_chg;
   logic cal_busy;
   logic cal_done;
   logic cal_found;
   logic sw_inv;
   logic [TAD_W-1:0] sw_coarse;
   logic res_inv;
   logic [TAD_W-1:0] res_coarse;
   logic [IRQ_N-1:0] ev;

   // ----------------------------------------
   // Window detector and calibration engine
   // ----------------------------------------
   swac_win #(
      .W(STAT_W),
      .DET(WIN_DET_CYC)
   ) u_win (
      .clk_in(MCLK_IN),
      .rst_n_in(ARST_N_IN),
      .ce_in(CE_IN),
      .restart_in(d.zoom != q.zoom),
      .taps_in(q.tap_s2),
      .status_out(win_status),
      .chg_out(win_chg)
   );

   swac_cal u_cal (
      .clk_in(MCLK_IN),
      .rst_n_in(ARST_N_IN),
      .ce_in(CE_IN),
      .en_in(q.cal_en),
      .settle_in(q.cfg),
      .align_in(q.al_s2),
      .inv_out(sw_inv),
      .coarse_out(sw_coarse),
      .busy_out(cal_busy),
      .done_out(cal_done),
      .found_out(cal_found),
      .res_inv_out(res_inv),
      .res_coarse_out(res_coarse)
   );

   // Events that set sticky interrupt status
   always_comb begin
      ev = '0;
      ev[IRQ_CAL_DONE] = cal_done & ~q.done_q;
      ev[IRQ_WIN_CHG] = win_chg;
      ev[IRQ_CAPT] = q.tap_s2[q.sel] & ~q.capt;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [31:0] wv;
      logic [31:0] rdat;
      logic [1:0] rrsp;
      logic [IRQ_N-1:0] clr;
      wv = 32'h0000_0000;
      rdat = 32'h0000_0000;
      rrsp = RESP_OKAY;
      clr = '0;
      d = q;
      d.tap_s1 = SYSREF_TAPS_IN;
      d.tap_s2 = q.tap_s1;
      d.al_s1 = ALIGN_IN;
      d.al_s2 = q.al_s1;
      d.capt = q.tap_s2[q.sel];
      d.done_q = cal_done;
      // Write channel: both address and data are taken together
      d.awrdy = 1'b0;
      d.wrdy = 1'b0;
      if (q.bvld && S_AXI_BREADY_IN) begin
         d.bvld = 1'b0;
      end
      if (!q.bvld && !q.awrdy && S_AXI_AWVALID_IN && S_AXI_WVALID_IN) begin
         d.awrdy = 1'b1;
         d.wrdy = 1'b1;
      end
      if (q.awrdy) begin
         d.bvld = 1'b1;
         d.bresp = RESP_OKAY;
         case (word_idx(S_AXI_AWADDR_IN))
            IDX_CLK_CTRL: begin
               wv = merge_wr({27'h0, q.zoom, q.sel}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
               d.sel = wv[SEL_W-1:0];
               d.zoom = wv[CTRL_ZOOM_BIT];
            end
            IDX_CAL_EN: begin
               wv = merge_wr({31'h0, q.cal_en}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
               d.cal_en = wv[0];
            end
            IDX_CAL_CFG: begin
               wv = merge_wr({24'h0, q.cfg}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
               d.cfg = wv[7:0];
            end
            IDX_TAD: begin
               wv = merge_wr({15'h0, q.tinv, q.tcoarse, q.tfine}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
               d.tfine = wv[TAD_W-1:0];
               d.tcoarse = wv[COARSE_DELAY_LSB +: TAD_W];
               d.tinv = wv[CLOCK_INVERT_BIT];
            end
            IDX_INT_EN: begin
               wv = merge_wr({29'h0, q.ien}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
               d.ien = wv[IRQ_N-1:0];
            end
            IDX_INT_CLR: begin
               wv = merge_wr(32'h0000_0000, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
               clr = wv[IRQ_N-1:0];
            end
            IDX_STAT_LO, IDX_STAT_MID, IDX_STAT_HI, IDX_CAL_STAT, IDX_INT_STAT: begin
            end
            default: begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end
      // Calibration result replaces the delay setting, winning over a write
      if (ev[IRQ_CAL_DONE]) begin
         d.tinv = res_inv;
         d.tcoarse = res_coarse;
      end
      d.ist = (q.ist & ~clr) | ev;
      d.irq = |(q.ist & q.ien);
      // Sweep drives the delay while searching, otherwise the register does
      d.o_inv = cal_busy ? sw_inv : q.tinv;
      d.o_coarse = cal_busy ? sw_coarse : q.tcoarse;
      d.o_fine = q.tfine;
      // Read channel
      d.arrdy = 1'b0;
      if (q.rvld && S_AXI_RREADY_IN) begin
         d.rvld = 1'b0;
      end
      if (!q.rvld && !q.arrdy && S_AXI_ARVALID_IN) begin
         d.arrdy = 1'b1;
      end
      if (q.arrdy) begin
         case (word_idx(S_AXI_ARADDR_IN))
            IDX_CLK_CTRL: rdat = {27'h0, q.zoom, q.sel};
            IDX_STAT_LO: rdat = {24'h0, win_status[7:0]};
            IDX_STAT_MID: rdat = {24'h0, win_status[15:8]};
            IDX_STAT_HI: rdat = {24'h0, win_status[23:16]};
            IDX_CAL_EN: rdat = {31'h0, q.cal_en};
            IDX_CAL_CFG: rdat = {24'h0, q.cfg};
            IDX_CAL_STAT: rdat = {13'h0, cal_found, cal_busy, cal_done, 7'h0, res_inv, res_coarse};
            IDX_TAD: rdat = {15'h0, q.tinv, q.tcoarse, q.tfine};
            IDX_INT_STAT: rdat = {29'h0, q.ist};
            IDX_INT_EN: rdat = {29'h0, q.ien};
            IDX_INT_CLR: rdat = 32'h0000_0000;
            default: rrsp = RESP_SLVERR;
         endcase
         d.rvld = 1'b1;
         d.rdata = rdat;
         d.rresp = rrsp;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         q <= '0;
         q.sel <= SEL_RST;
         q.zoom <= ZOOM_RST;
         q.cfg <= CAL_CFG_RST;
         q.tcoarse <= TAD_RST;
         q.tfine <= TAD_RST;
      end else if (CE_IN) begin
         q <= d;
      end
   end

   assign S_AXI_AWREADY_OUT = q.awrdy;
   assign S_AXI_WREADY_OUT = q.wrdy;
   assign S_AXI_BVALID_OUT = q.bvld;
   assign S_AXI_BRESP_OUT = q.bresp;
   assign S_AXI_ARREADY_OUT = q.arrdy;
   assign S_AXI_RVALID_OUT = q.rvld;
   assign S_AXI_RDATA_OUT = q.rdata;
   assign S_AXI_RRESP_OUT = q.rresp;
   assign WINDOW_ZOOM_OUT = q.zoom;
   assign SYSREF_CAPT_OUT = q.capt;
   assign CLOCK_INVERT_OUT = q.o_inv;
   assign COARSE_DELAY_OUT = q.o_coarse;
   assign FINE_DELAY_OUT = q.o_fine;
   assign CAL_DONE_OUT = q.done_q;
   assign IRQ_OUT = q.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!ARST_N_IN);

   sequence s_wr_take;
      CE_IN && q.awrdy;
   endsequence

   chk_capt_tap: assert property (CE_IN |=> SYSREF_CAPT_OUT == $past(q.tap_s2[q.sel]))
      else $error("capture not taken from selected tap");
   chk_sel_write: assert property (s_wr_take ##0 (word_idx(S_AXI_AWADDR_IN) == IDX_CLK_CTRL
      && S_AXI_WSTRB_IN[0]) |=> q.sel == $past(S_AXI_WDATA_IN[3:0]))
      else $error("select write not stored");
   chk_write_resp: assert property (s_wr_take |=> S_AXI_BVALID_OUT)
      else $error("write response missing");
   chk_done_copy: assert property (CE_IN && ev[IRQ_CAL_DONE]
      |=> q.tinv == $past(res_inv) && q.tcoarse == $past(res_coarse))
      else $error("calibration result not kept");
   chk_sweep_out: assert property (CE_IN && cal_busy |=> COARSE_DELAY_OUT == $past(sw_coarse))
      else $error("sweep delay not driven");
   chk_set_wins: assert property (CE_IN && ev != '0 |=> (q.ist & $past(ev)) == $past(ev))
      else $error("interrupt event lost");
   chk_irq_level: assert property (CE_IN |=> IRQ_OUT == $past(|(q.ist & q.ien)))
      else $error("interrupt level wrong");
endmodule
`default_nettype wire

/* File: test/swac_src_model.sv */
// Clock source model: periodic reference seen through the delay taps, alignment flag
`timescale 1ns/1ps
`default_nettype none
module swac_src_model
   import swac_pkg::*;
(
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic [4:0] edge_in,
   input wire logic [TAD_W-1:0] hit0_in,
   input wire logic [TAD_W-1:0] hit1_in,
   input wire logic inv_in,
   input wire logic [TAD_W-1:0] coarse_in,
   output logic [STAT_W-1:0] taps_out,
   output logic align_out
);
   logic ref_q = 1'b0;
   logic [1:0] cnt_q = 2'h0;
   // Continuous periodic reference while running, parked low otherwise
   always_ff @(posedge clk_in) begin
      cnt_q <= cnt_q + 2'h1;
      if (!run_in) begin
         ref_q <= 1'b0;
      end else if (cnt_q == 2'h2) begin
         ref_q <= ~ref_q;
      end
   end
   // Taps at or above the edge sample the opposite phase
   always_comb begin
      for (int i = 0; i < STAT_W; i++) begin
         taps_out[i] = (i >= int'(edge_in)) ? ~ref_q : ref_q;
      end
   end
   // Aligned at one coarse setting for each clock polarity
   assign align_out = inv_in ? (coarse_in == hit1_in) : (coarse_in == hit0_in);
endmodule
`default_nettype wire

/* File: test/swac_top_tb.sv */
// Testbench: register sequences for the reference window and calibration block
`timescale 1ns/1ps
`default_nettype none
module swac_top_tb
   import swac_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic awv = 1'b0, wv = 1'b0, arv = 1'b0, rdy = 1'b0, run = 1'b1;
   logic ce = 1'b1;
   logic [AXI_AW-1:0] addr = '0;
   logic [31:0] wd = '0;
   logic [3:0] st = 4'hF;
   logic [4:0] edge_k = 5'h0A;
   logic [TAD_W-1:0] hit0 = 8'h05, hit1 = 8'h0C;
   logic awr, wrd, arr, bv, rv, aln, zoom, capt, inv, done, irq;
   logic [1:0] br, rr;
   logic [31:0] rdat;
   logic [STAT_W-1:0] taps;
   logic [TAD_W-1:0] crs, fine;
   int n_errors = 0;
   int checked = 0;
   initial begin
      forever #20 clk = ~clk;
   end
   swac_top DUT (.MCLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce), .S_AXI_AWADDR_IN(addr),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(st),
      .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
      .S_AXI_BREADY_IN(rdy), .S_AXI_ARADDR_IN(addr), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
      .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rdy),
      .SYSREF_TAPS_IN(taps), .ALIGN_IN(aln), .WINDOW_ZOOM_OUT(zoom), .SYSREF_CAPT_OUT(capt),
      .CLOCK_INVERT_OUT(inv), .COARSE_DELAY_OUT(crs), .FINE_DELAY_OUT(fine), .CAL_DONE_OUT(done),
      .IRQ_OUT(irq));
   swac_src_model SRC (.clk_in(clk), .run_in(run), .edge_in(edge_k), .hit0_in(hit0), .hit1_in(hit1),
      .inv_in(inv), .coarse_in(crs), .taps_out(taps), .align_out(aln));
   task automatic summarize();
      $display("Checks %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input bit hit);
      if (hit) begin
         n_errors++;
         $display("ERROR %0t wait timed out", $time);
         summarize();
      end
   endtask
   // One bus transfer; request held until its ready, response taken at its valid
   task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic [1:0] r);
      int n;
      logic a_ok;
      logic w_ok;
      n = 0;
      a_ok = 1'b0;
      w_ok = !w;
      @(posedge clk);
      addr <= {i, 2'b00};
      wd <= d;
      st <= s;
      awv <= w;
      wv <= w;
      arv <= !w;
      rdy <= 1'b1;
      // Each channel is released at the edge its own ready is seen
      do begin
         @(posedge clk);
         n++;
         if ((w ? awr : arr) === 1'b1) begin
            a_ok = 1'b1;
            awv <= 1'b0;
            arv <= 1'b0;
         end
         if (w && wrd === 1'b1) begin
            w_ok = 1'b1;
            wv <= 1'b0;
         end
      end while (!(a_ok && w_ok) && n < 99);
      while ((w ? bv : rv) !== 1'b1 && n < 99) begin
         @(posedge clk);
         n++;
      end
      rdy <= 1'b0;
      q = rdat;
      r = w ? br : rr;
      tmo(n >= 99);
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0] r;
      acc(1'b1, i, d, 4'hF, q, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask
   task automatic rdc(input logic [7:0] i, input logic [31:0] exp);
      logic [31:0] q;
      logic [1:0] r;
      acc(1'b0, i, 32'h0, 4'hF, q, r);
      chk(q, exp);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      tmo(n >= 20000);
   endtask
   initial begin
      logic [31:0] q;
      logic [1:0] r;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rdc(IDX_CLK_CTRL, 32'h10);
      rdc(IDX_STAT_LO, 32'h01);
      rdc(IDX_STAT_MID, 32'h00);
      rdc(IDX_STAT_HI, 32'h80);
      rdc(IDX_CAL_CFG, 32'h20);
      rdc(IDX_CAL_STAT, 32'h0);
      chk(32'(zoom), 32'h1);
      // Two full detection intervals with the reference edge between taps 9 and 10
      repeat (9000) @(posedge clk);
      rdc(IDX_STAT_LO, 32'h01);
      rdc(IDX_STAT_MID, 32'h06);
      rdc(IDX_STAT_HI, 32'h80);
      // Tap 4 sits midway in the valid run of taps 1 to 8, lower side preferred
      wr(IDX_CLK_CTRL, 32'h14);
      rdc(IDX_CLK_CTRL, 32'h14);
      rdc(IDX_INT_STAT, 32'h6);
      wr(IDX_INT_EN, 32'h2);
      repeat (2) @(negedge clk);
      chk(32'(irq), 32'h1);
      wr(IDX_INT_CLR, 32'h2);
      repeat (2) @(negedge clk);
      chk(32'(irq), 32'h0);
      rdc(IDX_INT_STAT, 32'h4);
      rdc(IDX_INT_CLR, 32'h0);
      acc(1'b1, 8'h00, 32'h1, 4'hF, q, r);
      chk(32'(r), 32'(RESP_SLVERR));
      acc(1'b0, 8'h3F, 32'h0, 4'hF, q, r);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(IDX_STAT_LO, 32'hFF);
      rdc(IDX_STAT_LO, 32'h01);
      // Reference parked low: taps 10 and up read high
      run <= 1'b0;
      wr(IDX_CLK_CTRL, 32'h1A);
      repeat (4) @(negedge clk);
      chk(32'({zoom, capt}), 32'h3);
      wr(IDX_CLK_CTRL, 32'h29);
      repeat (4) @(negedge clk);
      chk(32'({zoom, capt}), 32'h0);
      rdc(IDX_CLK_CTRL, 32'h09);
      // Clock enable low freezes the capture path while tap 9 flips
      @(posedge clk);
      ce <= 1'b0;
      edge_k <= 5'h09;
      repeat (6) @(negedge clk);
      chk(32'(capt), 32'h0);
      @(posedge clk);
      ce <= 1'b1;
      repeat (5) @(negedge clk);
      chk(32'(capt), 32'h1);
      @(posedge clk);
      edge_k <= 5'h0A;
      run <= 1'b1;
      wr(IDX_CLK_CTRL, 32'h10);
      wr(IDX_INT_EN, 32'h1);
      wr(IDX_INT_CLR, 32'h7);
      repeat (2) @(negedge clk);
      chk(32'(irq), 32'h0);
      // No converter calibration runs alongside
      wr(IDX_CAL_CFG, 32'h04);
      wr(IDX_CAL_EN, 32'h1);
      wait_done();
      rdc(IDX_CAL_STAT, 32'h00050005);
      chk(32'({inv, crs}), 32'h005);
      rdc(IDX_TAD, 32'h0500);
      chk(32'(irq), 32'h1);
      wr(IDX_CAL_EN, 32'h0);
      repeat (2) @(negedge clk);
      chk(32'({done, inv, crs}), 32'h005);
      acc(1'b1, IDX_TAD, 32'h00010722, 4'h5, q, r);
      chk(32'(r), 32'(RESP_OKAY));
      rdc(IDX_TAD, 32'h00010522);
      chk(32'({inv, crs, fine}), 32'h10522);
      hit0 <= 8'h09;
      hit1 <= 8'h03;
      wr(IDX_CAL_EN, 32'h1);
      wait_done();
      rdc(IDX_CAL_STAT, 32'h00050103);
      chk(32'({inv, crs}), 32'h103);
      wr(IDX_CAL_EN, 32'h0);
      repeat (2) @(negedge clk);
      chk(32'(done), 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
